// [hdl/sfes_pkg.sv]
// Package with constants and carrier types for the SIMD exception sequencer.
package sfes_pkg;

	// ==========================================================================
	// Exception field layout
	// ==========================================================================
	localparam int SFES_NUM_EXC = 6;
	localparam int SFES_FLAG_LSB = 0;
	localparam int SFES_MASK_LSB = 7;
	localparam int SFES_MASK_MSB = 12;
	localparam int SFES_RC_LSB = 13;
	localparam int SFES_CSR_W = 16;
	// Bit index of each exception within the six-bit flag and mask fields.
	localparam int SFES_EXC_INV = 0;
	localparam int SFES_EXC_DEN = 1;
	localparam int SFES_EXC_DIV = 2;
	localparam int SFES_EXC_OVF = 3;
	localparam int SFES_EXC_UNF = 4;
	localparam int SFES_EXC_PRE = 5;
	localparam logic [5:0] SFES_PRE_SET = 6'h07;
	localparam logic [5:0] SFES_POST_SET = 6'h38;
	localparam logic [5:0] SFES_MASK_RST = 6'h3F;
	localparam logic [5:0] SFES_FLAG_RST = 6'h00;
	localparam logic [1:0] SFES_RC_RST = 2'h0;

	// ==========================================================================
	// Control register and identification bits
	// ==========================================================================
	localparam int SFES_CR4_OSXF_BIT = 10;
	localparam int SFES_NUMERIC_ERROR_ENABLE_BIT = 5;
	localparam int SFES_ID_FLAG_BIT = 21;
	localparam int SFES_ID_EXT1_BIT = 25;
	localparam int SFES_ID_EXT2_BIT = 26;
	localparam logic [31:0] SFES_ID_LEAF_ONE = 32'h0000_0001;

	// ==========================================================================
	// Carrier types
	// ==========================================================================
	typedef struct packed {
		logic valid;
		logic is_simd;
		logic supported;
		logic is_trunc_store;
	} sfes_instr_t;

	typedef struct packed {
		logic [5:0] pre;
		logic [5:0] post;
	} sfes_cond_t;

	typedef enum logic [1:0] {
		SFES_FAULT_NONE,
		SFES_FAULT_SIMD,
		SFES_FAULT_UNDEF
	} sfes_fault_t;

endpackage : sfes_pkg

// [hdl/sfes_fault_sel.sv]
// Fault selection between the SIMD fault and the undefined-opcode fault.
`timescale 1ns/1ps
module sfes_fault_sel
	import sfes_pkg::*;
(
	// Inputs
	input wire logic [5:0] unmasked_new,
	input wire logic os_support,
	// Result
	output sfes_fault_t fault
);

	always_comb begin
		if (unmasked_new == 6'h00) begin
			fault = SFES_FAULT_NONE;
		end else if (!os_support) begin
			fault = SFES_FAULT_UNDEF;
		end else begin
			fault = SFES_FAULT_SIMD;
		end
	end

endmodule : sfes_fault_sel

// [hdl/sfes_ident.sv]
// Identification response for the processor identify instruction.
`timescale 1ns/1ps
module sfes_ident
	import sfes_pkg::*;
#(
	parameter bit EXT1_PRESENT = 1'b1,
	parameter bit EXT2_PRESENT = 1'b1
) (
	// Query
	input wire logic [31:0] leaf,
	// Answer
	output logic [31:0] edx
);

	always_comb begin
		edx = 32'h0000_0000;
		if (leaf == SFES_ID_LEAF_ONE) begin
			edx[SFES_ID_EXT1_BIT] = EXT1_PRESENT;
			edx[SFES_ID_EXT2_BIT] = EXT2_PRESENT;
		end
	end

endmodule : sfes_ident

// [hdl/sfes_seq.sv]
// Top-level SIMD floating-point exception sequencer.
//
// Functional notes
// - Detect pre-computation conditions first, OR them, set flags, keep operands.
// - On unmasked condition with OS support bit clear, raise undefined-opcode fault.
// - With OS support bit set, raise SIMD fault and call its handler.
// - No pre-computation condition means go straight to post-computation check.
// - After handler return, check post conditions, set flags, fault again if unmasked.
// - Complete only after post handler returns or no unmasked post condition; two faults possible.
// - Mixed masked and unmasked conditions set flags for both kinds.
// - Masked results are withheld until unmasked post faults are handled.
// - SIMD exceptions never assert the legacy floating-point error pin.
// - SIMD handling ignores the ignore-numeric-error pin entirely.
// - SIMD and x87 exception masks are held independently.
// - SIMD and x87 rounding controls do not influence each other.
// - Unmasking an already-set flag does not fault; only new occurrences do.
// - A writable flags-register bit shows support for the identify instruction.
// - Identify leaf one reports both SIMD extensions in EDX bits 25 and 26.
// - Unsupported SIMD instruction raises an undefined-opcode fault.
// - SIMD instruction without OS SIMD state support raises undefined-opcode fault.
// - Truncating integer store reports only x87 invalid and inexact exceptions.
// - Pre set is invalid, divide, denormal; post set is overflow, underflow, inexact.
// - Flags in bits 0-5, masks 7-12; reset sets masks, clears flags.
`timescale 1ns/1ps
module sfes_seq
	import sfes_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Instruction issue and conditions
	input sfes_instr_t instr,
	input sfes_cond_t cond,
	input wire logic [5:0] x87_cond,
	// Handler return, software writes, control registers, ignore pin and identify leaf
	input wire logic handler_return,
	input wire logic csr_wr,
	input wire logic [SFES_CSR_W-1:0] csr_wdata,
	input wire logic [5:0] x87_mask_wr_val,
	input wire logic x87_mask_wr,
	input wire logic [1:0] x87_rc_wr_val,
	input wire logic x87_rc_wr,
	input wire logic id_flag_wr,
	input wire logic id_flag_wr_val,
	input wire logic [31:0] control_register_four,
	input wire logic [31:0] control_register_zero,
	input wire logic ignore_numeric_error_pin,
	input wire logic [31:0] id_leaf,
	// Status and results
	output logic [SFES_CSR_W-1:0] simd_fp_control_status,
	output logic [5:0] x87_status,
	output logic [5:0] x87_mask,
	output logic [1:0] x87_rc,
	output logic busy,
	output logic simd_fp_fault,
	output logic undefined_opcode_fault,
	output logic result_write,
	output logic instr_done,
	output logic legacy_fp_error_pin,
	output logic processor_flags_id,
	output logic [31:0] id_edx
);

	// ==========================================================================
	// Sequencer state
	// ==========================================================================
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PRE,
		ST_PRE_WAIT,
		ST_POST,
		ST_POST_WAIT
	} sfes_state_t;

	sfes_state_t state_ff, nxt_state;
	logic [5:0] flag_ff, nxt_flag;
	logic [5:0] mask_ff, nxt_mask;
	logic [1:0] rc_ff, nxt_rc;
	logic [5:0] x87_flag_ff, nxt_x87_flag;
	logic [5:0] x87_mask_ff, nxt_x87_mask;
	logic [1:0] x87_rc_ff, nxt_x87_rc;
	logic [5:0] post_ff, nxt_post;
	logic simd_fault_ff, nxt_simd_fault;
	logic ud_fault_ff, nxt_ud_fault;
	logic wr_ff, nxt_wr;
	logic done_ff, nxt_done;
	logic idf_ff, nxt_idf;
	logic busy_ff, nxt_busy;
	logic [31:0] edx_ff;
	logic [31:0] edx_w;
	logic os_support;
	logic [5:0] sel_cond;
	sfes_fault_t fault_w;

	assign os_support = control_register_four[SFES_CR4_OSXF_BIT];

	// Condition under test in the current step, restricted to its class.
	always_comb begin
		sel_cond = 6'h00;
		if (state_ff == ST_PRE) begin
			sel_cond = cond.pre & SFES_PRE_SET;
		end else if (state_ff == ST_POST) begin
			sel_cond = post_ff & SFES_POST_SET;
		end
	end

	// Only unmasked conditions detected in this instruction can fault,
	// so a stale sticky flag never faults by itself.
	sfes_fault_sel u_fault_sel (
		.unmasked_new(sel_cond & ~mask_ff),
		.os_support(os_support),
		.fault(fault_w)
	);

	sfes_ident u_ident (
		.leaf(id_leaf),
		.edx(edx_w)
	);

	// ==========================================================================
	// Next-state logic
	// ==========================================================================
	always_comb begin
		nxt_state = state_ff;
		nxt_flag = flag_ff;
		nxt_mask = mask_ff;
		nxt_rc = rc_ff;
		nxt_x87_flag = x87_flag_ff;
		nxt_x87_mask = x87_mask_ff;
		nxt_x87_rc = x87_rc_ff;
		nxt_post = post_ff;
		nxt_simd_fault = 1'b0;
		nxt_ud_fault = 1'b0;
		nxt_wr = 1'b0;
		nxt_done = 1'b0;
		nxt_idf = idf_ff;
		if (id_flag_wr) begin
			nxt_idf = id_flag_wr_val;
		end
		// Software writes to control words; SIMD and x87 copies are separate.
		if (csr_wr) begin
			nxt_flag = csr_wdata[SFES_FLAG_LSB +: SFES_NUM_EXC];
			nxt_mask = csr_wdata[SFES_MASK_LSB +: SFES_NUM_EXC];
			nxt_rc = csr_wdata[SFES_RC_LSB +: 2];
		end
		if (x87_mask_wr) begin
			nxt_x87_mask = x87_mask_wr_val;
		end
		if (x87_rc_wr) begin
			nxt_x87_rc = x87_rc_wr_val;
		end
		case (state_ff)
			ST_IDLE: begin
				if (instr.valid && instr.is_trunc_store) begin
					// Only x87 invalid and inexact are reported here.
					nxt_x87_flag = x87_flag_ff | (x87_cond & ((6'h01 << SFES_EXC_INV) |
						(6'h01 << SFES_EXC_PRE)));
					nxt_done = 1'b1;
				end else if (instr.valid && instr.is_simd) begin
					if (!instr.supported || !os_support) begin
						nxt_ud_fault = 1'b1;
					end else begin
						nxt_post = cond.post;
						nxt_state = ST_PRE;
					end
				end
			end
			ST_PRE: begin
				// Flags for masked and unmasked conditions alike; set beats a write.
				nxt_flag = nxt_flag | sel_cond;
				if (fault_w == SFES_FAULT_NONE) begin
					nxt_state = ST_POST;
				end else begin
					nxt_simd_fault = (fault_w == SFES_FAULT_SIMD);
					nxt_ud_fault = (fault_w == SFES_FAULT_UNDEF);
					nxt_state = ST_PRE_WAIT;
				end
			end
			ST_PRE_WAIT: begin
				if (handler_return) begin
					nxt_post = cond.post;
					nxt_state = ST_POST;
				end
			end
			ST_POST: begin
				nxt_flag = nxt_flag | sel_cond;
				if (fault_w == SFES_FAULT_NONE) begin
					nxt_wr = 1'b1;
					nxt_done = 1'b1;
					nxt_state = ST_IDLE;
				end else begin
					nxt_simd_fault = (fault_w == SFES_FAULT_SIMD);
					nxt_ud_fault = (fault_w == SFES_FAULT_UNDEF);
					nxt_state = ST_POST_WAIT;
				end
			end
			ST_POST_WAIT: begin
				if (handler_return) begin
					nxt_wr = 1'b1;
					nxt_done = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		nxt_busy = (nxt_state != ST_IDLE);
	end

	// ==========================================================================
	// Registers
	// ==========================================================================
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			flag_ff <= SFES_FLAG_RST;
			mask_ff <= SFES_MASK_RST;
			rc_ff <= SFES_RC_RST;
			x87_flag_ff <= SFES_FLAG_RST;
			x87_mask_ff <= SFES_MASK_RST;
			x87_rc_ff <= SFES_RC_RST;
			post_ff <= 6'h00;
			simd_fault_ff <= 1'b0;
			ud_fault_ff <= 1'b0;
			wr_ff <= 1'b0;
			done_ff <= 1'b0;
			idf_ff <= 1'b0;
			busy_ff <= 1'b0;
			edx_ff <= 32'h0000_0000;
		end else begin
			state_ff <= nxt_state;
			flag_ff <= nxt_flag;
			mask_ff <= nxt_mask;
			rc_ff <= nxt_rc;
			x87_flag_ff <= nxt_x87_flag;
			x87_mask_ff <= nxt_x87_mask;
			x87_rc_ff <= nxt_x87_rc;
			post_ff <= nxt_post;
			simd_fault_ff <= nxt_simd_fault;
			ud_fault_ff <= nxt_ud_fault;
			wr_ff <= nxt_wr;
			done_ff <= nxt_done;
			idf_ff <= nxt_idf;
			busy_ff <= nxt_busy;
			edx_ff <= edx_w;
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	// The legacy error pin and numeric-error controls play no part here.
	always_comb begin
		simd_fp_control_status = '0;
		simd_fp_control_status[SFES_FLAG_LSB +: SFES_NUM_EXC] = flag_ff;
		simd_fp_control_status[SFES_MASK_LSB +: SFES_NUM_EXC] = mask_ff;
		simd_fp_control_status[SFES_RC_LSB +: 2] = rc_ff;
	end
	assign x87_status = x87_flag_ff;
	assign x87_mask = x87_mask_ff;
	assign x87_rc = x87_rc_ff;
	assign busy = busy_ff;
	assign simd_fp_fault = simd_fault_ff;
	assign undefined_opcode_fault = ud_fault_ff;
	assign result_write = wr_ff;
	assign instr_done = done_ff;
	assign legacy_fp_error_pin = 1'b0;
	assign processor_flags_id = idf_ff;
	assign id_edx = edx_ff;

	// ==========================================================================
	// Assertions
	// ==========================================================================
	a_pre_flag_set: assert property (@(posedge mclk) disable iff (rst)
		(state_ff == ST_PRE) |=> ((flag_ff & $past(sel_cond)) == $past(sel_cond)))
		else $error("pre-computation flags not set");
	a_ud_no_os: assert property (@(posedge mclk) disable iff (rst)
		(state_ff == ST_PRE && fault_w != SFES_FAULT_NONE && !os_support) |=> undefined_opcode_fault)
		else $error("undefined-opcode fault missing");
	a_xm_with_os: assert property (@(posedge mclk) disable iff (rst)
		(state_ff == ST_POST && fault_w != SFES_FAULT_NONE && os_support) |=> simd_fp_fault && !undefined_opcode_fault)
		else $error("SIMD fault missing");
	a_skip_pre: assert property (@(posedge mclk) disable iff (rst)
		(state_ff == ST_PRE && fault_w == SFES_FAULT_NONE) |=> state_ff == ST_POST && !simd_fp_fault)
		else $error("pre step did not skip to post");
	a_done_gated: assert property (@(posedge mclk) disable iff (rst)
		(state_ff == ST_POST_WAIT && !handler_return) |=> !instr_done && !result_write)
		else $error("result released before handler return");
	a_post_return: assert property (@(posedge mclk) disable iff (rst)
		(state_ff == ST_POST_WAIT && handler_return) |=> instr_done ##1 !instr_done)
		else $error("completion pulse wrong");
	a_no_legacy_fp_error_pin: assert property (@(posedge mclk) disable iff (rst)
		simd_fp_fault |-> !legacy_fp_error_pin)
		else $error("legacy error pin asserted");
	a_stale_flag: assert property (@(posedge mclk) disable iff (rst)
		(state_ff == ST_PRE && sel_cond == 6'h00) |=> !simd_fp_fault && !undefined_opcode_fault)
		else $error("fault without new condition");
	a_unsup_ud: assert property (@(posedge mclk) disable iff (rst)
		(state_ff == ST_IDLE && instr.valid && instr.is_simd && !instr.is_trunc_store && !instr.supported)
		|=> undefined_opcode_fault && state_ff == ST_IDLE)
		else $error("unsupported instruction not refused");

endmodule : sfes_seq

// [verif/sfes_handler.sv]
// Behavioural model of the software handler that answers fault calls.
`timescale 1ns/1ps
module sfes_handler (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Fault calls and handler latency
	input wire logic simd_fp_fault,
	input wire logic undefined_opcode_fault,
	input wire logic [3:0] delay,
	// Return to the sequencer
	output logic handler_return,
	output logic pending
);
	logic [3:0] cnt;

	// =========================================================================
	// Call and return
	// =========================================================================
	always @(posedge mclk) begin
		handler_return <= 1'b0;
		if (rst) begin
			pending <= 1'b0;
			cnt <= 4'h0;
		end else if (simd_fp_fault || undefined_opcode_fault) begin
			pending <= 1'b1;
			cnt <= delay;
		end else if (pending && cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end else if (pending) begin
			pending <= 1'b0;
			handler_return <= 1'b1;
		end
	end
endmodule : sfes_handler

// [verif/sfes_seq_tb_top.sv]
// Self-checking testbench of the SIMD exception sequencer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module sfes_seq_tb_top;
	import sfes_pkg::*;
	logic mclk, rst, handler_return, hpend, csr_wr, x87_mask_wr, x87_rc_wr, id_flag_wr, id_flag_wr_val, ign;
	logic simd_fp_fault, undefined_opcode_fault, result_write, instr_done, legacy_fp_error_pin, busy, flags_id;
	sfes_instr_t instr;
	sfes_cond_t cond;
	logic [5:0] x87_cond, x87_mask_wr_val, x87_status, x87_mask;
	logic [1:0] x87_rc_wr_val, x87_rc;
	logic [15:0] csr_wdata, status;
	logic [31:0] cr4, cr0, id_leaf, id_edx;
	logic [3:0] hdelay;
	int n_mismatch, checks, n_xm, n_ud, n_rw, n_dn, cyc;

	// =========================================================================
	// Design, handler model and clock
	// =========================================================================
	sfes_seq DUT (.mclk(mclk), .rst(rst), .instr(instr), .cond(cond), .x87_cond(x87_cond),
		.handler_return(handler_return), .csr_wr(csr_wr), .csr_wdata(csr_wdata),
		.x87_mask_wr_val(x87_mask_wr_val), .x87_mask_wr(x87_mask_wr), .x87_rc_wr_val(x87_rc_wr_val),
		.x87_rc_wr(x87_rc_wr), .id_flag_wr(id_flag_wr), .id_flag_wr_val(id_flag_wr_val),
		.control_register_four(cr4), .control_register_zero(cr0), .ignore_numeric_error_pin(ign),
		.id_leaf(id_leaf), .simd_fp_control_status(status), .x87_status(x87_status), .x87_mask(x87_mask),
		.x87_rc(x87_rc), .busy(busy), .simd_fp_fault(simd_fp_fault), .undefined_opcode_fault(undefined_opcode_fault),
		.result_write(result_write), .instr_done(instr_done), .legacy_fp_error_pin(legacy_fp_error_pin),
		.processor_flags_id(flags_id), .id_edx(id_edx));
	sfes_handler u_handler (.mclk(mclk), .rst(rst), .simd_fp_fault(simd_fp_fault),
		.undefined_opcode_fault(undefined_opcode_fault), .delay(hdelay), .handler_return(handler_return),
		.pending(hpend));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Counts fault pulses and flags a result written while a handler is still running.
	always @(posedge mclk) begin
		cyc++;
		if (!rst) begin
			if (simd_fp_fault === 1'b1) n_xm++;
			if (undefined_opcode_fault === 1'b1) n_ud++;
			if (result_write === 1'b1) n_rw++;
			if (instr_done === 1'b1) n_dn++;
			if (result_write === 1'b1) `CHK("write_while_pending", 1'b0, hpend)
			`CHK("legacy_pin", 1'b0, legacy_fp_error_pin)
		end
		if (cyc == 5000) begin
			n_mismatch++;
			complete_run();
		end
	end

	// =========================================================================
	// Shared tasks
	// =========================================================================
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	task automatic csr_write(input logic [15:0] v);
		@(posedge mclk);
		csr_wr <= 1'b1;
		csr_wdata <= v;
		@(posedge mclk);
		csr_wr <= 1'b0;
		@(posedge mclk);
	endtask : csr_write

	// Issues one instruction, holds its conditions until the sequencer is idle and no handler call runs.
	// An instruction refused at issue never completes, so the caller states how many completions it expects.
	task automatic run(input logic [3:0] kind, input logic [5:0] pre, input logic [5:0] post, input int exp_dn);
		int k;
		n_xm = 0;
		n_ud = 0;
		n_rw = 0;
		n_dn = 0;
		k = 0;
		@(posedge mclk);
		instr <= kind;
		cond <= '{pre: pre, post: post};
		@(posedge mclk);
		instr <= '0;
		while ((k < 3 || busy !== 1'b0 || hpend !== 1'b0) && k < 80) begin
			@(posedge mclk);
			k++;
		end
		cond <= '0;
		@(posedge mclk);
		`CHK("done_seen", exp_dn, n_dn)
		`CHK("idle_reached", 1'b0, busy)
	endtask : run

	// =========================================================================
	// Scenarios
	// =========================================================================
	task automatic t_pre_fault();
		csr_write(16'h0000);
		cr0 <= 32'h0000_0020;
		ign <= 1'b1;
		run(4'hE, 6'h01, 6'h00, 1);
		`CHK("pre_xm", 1, n_xm)
		`CHK("pre_ignore_pin", 0, n_ud)
		`CHK("pre_flags", 6'h01, status[5:0])
		ign <= 1'b0;
	endtask : t_pre_fault

	task automatic t_os_off();
		hdelay <= 4'h6;
		// The support bit drops just after issue, so the sequence step itself must pick the fault.
		fork
			run(4'hE, 6'h02, 6'h00, 1);
			begin
				repeat (2) @(posedge mclk);
				cr4 <= 32'h0;
			end
		join
		`CHK("seq_ud", 1, n_ud)
		`CHK("seq_xm", 0, n_xm)
		run(4'hE, 6'h02, 6'h00, 0);
		`CHK("os_off_ud", 1, n_ud)
		`CHK("os_off_xm", 0, n_xm)
		cr4 <= 32'h0000_0400;
	endtask : t_os_off

	task automatic t_no_pre();
		csr_write(16'h0000);
		run(4'hE, 6'h00, 6'h00, 1);
		`CHK("no_pre_xm", 0, n_xm)
		`CHK("no_pre_write", 1, n_rw)
	endtask : t_no_pre

	task automatic t_twice();
		hdelay <= 4'h0;
		run(4'hE, 6'h04, 6'h08, 1);
		`CHK("twice_xm", 2, n_xm)
		`CHK("twice_flags", 6'h0C, status[5:0])
	endtask : t_twice

	task automatic t_mixed();
		csr_write(16'h0400);
		hdelay <= 4'h9;
		run(4'hE, 6'h00, 6'h18, 1);
		`CHK("mixed_xm", 1, n_xm)
		`CHK("mixed_flags", 6'h18, status[5:0])
		`CHK("mixed_write", 1, n_rw)
	endtask : t_mixed

	task automatic t_sticky();
		csr_write(16'h003F);
		run(4'hE, 6'h00, 6'h00, 1);
		`CHK("sticky_xm", 0, n_xm)
		run(4'hE, 6'h01, 6'h00, 1);
		`CHK("sticky_new_xm", 1, n_xm)
	endtask : t_sticky

	task automatic t_unsup();
		run(4'hC, 6'h00, 6'h00, 0);
		`CHK("unsup_ud", 1, n_ud)
		`CHK("unsup_write", 0, n_rw)
	endtask : t_unsup

	task automatic t_x87();
		csr_write(16'h3F80);
		x87_mask_wr <= 1'b1;
		x87_mask_wr_val <= 6'h15;
		x87_rc_wr <= 1'b1;
		x87_rc_wr_val <= 2'h3;
		@(posedge mclk);
		x87_mask_wr <= 1'b0;
		x87_rc_wr <= 1'b0;
		@(posedge mclk);
		@(posedge mclk);
		`CHK("simd_csr", 16'h3F80, status)
		`CHK("x87_mask", 6'h15, x87_mask)
		`CHK("x87_rc", 2'h3, x87_rc)
	endtask : t_x87

	task automatic t_trunc();
		csr_write(16'h0000);
		x87_cond <= 6'h21;
		run(4'h9, 6'h01, 6'h08, 1);
		`CHK("trunc_x87", 6'h21, x87_status)
		`CHK("trunc_simd", 6'h00, status[5:0])
		`CHK("trunc_xm", 0, n_xm)
	endtask : t_trunc

	task automatic t_ident();
		id_leaf <= 32'h0000_0001;
		id_flag_wr <= 1'b1;
		id_flag_wr_val <= 1'b1;
		@(posedge mclk);
		id_flag_wr <= 1'b0;
		@(posedge mclk);
		@(posedge mclk);
		`CHK("ident_ext", 2'h3, id_edx[26:25])
		`CHK("ident_flag", 1'b1, flags_id)
	endtask : t_ident

	initial begin
		{rst, csr_wr, x87_mask_wr, x87_rc_wr, id_flag_wr, id_flag_wr_val, ign} = 7'h40;
		{n_mismatch, checks, n_xm, n_ud, n_rw, cyc} = '0;
		instr = '0;
		cond = '0;
		{x87_cond, x87_mask_wr_val, x87_rc_wr_val, csr_wdata} = '0;
		{cr0, id_leaf} = '0;
		cr4 = 32'h0000_0400;
		hdelay = 4'h2;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		@(posedge mclk);
		`CHK("reset_csr", 16'h1F80, status)
		t_pre_fault();
		t_os_off();
		t_no_pre();
		t_twice();
		t_mixed();
		t_sticky();
		t_unsup();
		t_x87();
		t_trunc();
		t_ident();
		complete_run();
	end
endmodule : sfes_seq_tb_top
